// File: hdl/sse_store_stop.sv
`timescale 1ns/1ps
// How it works
// - Byte store: N from bit 7, Z if byte zero, V cleared, C kept.
// - Accumulator stores: 97/A7/B7 for A, D7/E7/F7 for B, prefix 18 selects Y.
// - Direct writes 00dd; indexed adds idle read at FFFF; only writes drive rw low.
// - Double store writes A then B at next address; accumulators unchanged.
// - Double store: N from bit 15, Z if all sixteen bits zero, V cleared.
// - Stop with stop-disable set acts as no-operation; flags never touched.
// - Stop with stop-disable clear halts system clocks into standby.
// - While stopped all registers and bus pins hold their values.
// - Only reset, non-maskable line or unmasked interrupt leave stop.
// - Non-maskable wake with its mask clear hands over to stacking sequence.
// - Non-maskable wake with mask set resumes at the next opcode fetch.
// - Stop decodes as one byte only without a prefix; after prefix 18 or CD it is trapped as illegal.
// - Stack pointer store writes high byte then low byte at address plus one.
// - Stack pointer store: N from bit 15, Z if pointer zero, V cleared.
// - Index X store writes high byte then low byte at next address.
module sse_store_stop
  import sse_pkg::*;
(
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET_N,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Processor bus
  input  wire logic [7:0]  I_BUS_DIN,
  output sse_pkg::sse_bus_t O_BUS,
  // Interrupt lines, active low pins
  input  wire logic        I_NONMASKABLE_INT_LINE_N,
  input  wire logic        I_IRQ_N,
  // Standby and hand-over
  output logic             O_CLK_HALT,
  output logic             O_NONMASKABLE_INT_LINE_STACK,
  output logic             O_IRQ_WAKE
);
  import sse_pkg::*;

  sse_state_t  state_r, state_nxt;
  sse_bus_t    bus_r, bus_nxt;
  sse_dec_t    dec_r, dec_nxt;
  logic [7:0]  prefix_r, prefix_nxt;
  logic [15:0] ea_r, ea_nxt;
  logic [7:0]  ext_hi_r, ext_hi_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0]  ccr_r, ccr_nxt;
  logic [7:0]  acc_a_r, acc_b_r;
  logic [15:0] idx_x_r, idx_y_r, sp_r;
  logic        run_r, run_clr;
  logic        illeg_r, illeg_set;
  logic        halt_nxt, stack_nxt, irqw_nxt;
  logic [1:0]  nonmaskable_int_line_sync_r, irq_sync_r;
  logic        nonmaskable_int_line_act, irq_act;
  logic        apb_acc, apb_wr;
  logic [15:0] val16;
  logic [31:0] rd_val;
  logic        addr_ok;

  // Bits 5:4 pick the mode, low nibble and bit 6 pick the source
  function automatic sse_dec_t decode(input logic [7:0] op);
    sse_dec_t d;
    d = '{valid: 1'b0, mode: AM_NONE, src: SRC_A, wide: 1'b0};
    if (op[7] && (op[5:4] != 2'b00) && (op[7:6] != 2'b11 || op[3:0] != 4'hD || op[5:4] != 2'b00))
    begin
      d.mode = sse_mode_t'(op[5:4]);
      if (op[3:0] == 4'h7)
      begin
        d.valid = 1'b1;
        d.src   = op[6] ? SRC_B : SRC_A;
      end
      else if (op[3:0] == 4'hD && op[6])
      begin
        d.valid = 1'b1;
        d.src   = SRC_D;
        d.wide  = 1'b1;
      end
      else if (op[3:0] == 4'hF)
      begin
        d.valid = 1'b1;
        d.src   = op[6] ? SRC_X : SRC_SP;
        d.wide  = 1'b1;
      end
    end
    return d;
  endfunction : decode

  // Pins from outside; only the second stage is looked at
  always_ff @(posedge I_MCLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      nonmaskable_int_line_sync_r <= 2'b11;
      irq_sync_r  <= 2'b11;
    end
    else
    begin
      nonmaskable_int_line_sync_r <= {nonmaskable_int_line_sync_r[0], I_NONMASKABLE_INT_LINE_N};
      irq_sync_r  <= {irq_sync_r[0], I_IRQ_N};
    end
  end
  assign nonmaskable_int_line_act = ~nonmaskable_int_line_sync_r[1];
  assign irq_act  = ~irq_sync_r[1];

  always_comb
  begin
    case (dec_r.src)
      SRC_A:   val16 = {acc_a_r, 8'h00};
      SRC_B:   val16 = {acc_b_r, 8'h00};
      SRC_D:   val16 = {acc_a_r, acc_b_r};
      SRC_SP:  val16 = sp_r;
      default: val16 = idx_x_r;
    endcase
  end

  always_comb
  begin
    state_nxt  = state_r;
    bus_nxt    = bus_r;
    dec_nxt    = dec_r;
    prefix_nxt = prefix_r;
    ea_nxt     = ea_r;
    ext_hi_nxt = ext_hi_r;
    pc_nxt     = pc_r;
    ccr_nxt    = ccr_r;
    run_clr    = 1'b0;
    illeg_set  = 1'b0;
    halt_nxt   = 1'b0;
    stack_nxt  = 1'b0;
    irqw_nxt   = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        bus_nxt.rw = 1'b1;
        if (run_r)
        begin
          state_nxt = ST_FETCH;
          bus_nxt   = '{addr: pc_r, data: 8'h00, rw: 1'b1};
        end
      end
      ST_FETCH:
      begin
        pc_nxt       = pc_r + 16'h0001;
        bus_nxt      = '{addr: pc_r + 16'h0001, data: 8'h00, rw: 1'b1};
        dec_nxt      = decode(I_BUS_DIN);
        prefix_nxt   = 8'h00;
        if (I_BUS_DIN == OPC_PRE_Y || I_BUS_DIN == OPC_PRE_XY)
        begin
          prefix_nxt = I_BUS_DIN;
          state_nxt  = ST_PREFIX;
        end
        else if (I_BUS_DIN == OPC_STOP)
          state_nxt = ST_INH;
        else if (dec_nxt.valid)
          state_nxt = ST_OPR1;
        else
        begin
          illeg_set = 1'b1;
          run_clr   = 1'b1;
          state_nxt = ST_IDLE;
          bus_nxt   = '{addr: IDLE_ADDR, data: 8'h00, rw: 1'b1};
        end
      end
      ST_PREFIX:
      begin
        pc_nxt  = pc_r + 16'h0001;
        bus_nxt = '{addr: pc_r + 16'h0001, data: 8'h00, rw: 1'b1};
        dec_nxt = decode(I_BUS_DIN);
        // 18 takes the accumulator and pointer forms, CD only the X store
        if (dec_nxt.valid && dec_nxt.mode == AM_IND &&
            ((prefix_r == OPC_PRE_Y && dec_nxt.src != SRC_X) ||
             (prefix_r == OPC_PRE_XY && I_BUS_DIN == OPC_STX_IND)))
          state_nxt = ST_OPR1;
        else
        begin
          illeg_set = 1'b1;
          run_clr   = 1'b1;
          state_nxt = ST_IDLE;
          bus_nxt   = '{addr: IDLE_ADDR, data: 8'h00, rw: 1'b1};
        end
      end
      ST_OPR1:
      begin
        pc_nxt = pc_r + 16'h0001;
        if (dec_r.mode == AM_DIR)
        begin
          ea_nxt    = {8'h00, I_BUS_DIN};
          state_nxt = ST_WR_HI;
          bus_nxt   = '{addr: {8'h00, I_BUS_DIN}, data: val16[15:8], rw: 1'b0};
        end
        else if (dec_r.mode == AM_EXT)
        begin
          ext_hi_nxt = I_BUS_DIN;
          state_nxt  = ST_OPR2;
          bus_nxt    = '{addr: pc_r + 16'h0001, data: 8'h00, rw: 1'b1};
        end
        else
        begin
          ea_nxt    = (prefix_r != 8'h00 ? idx_y_r : idx_x_r) + {8'h00, I_BUS_DIN};
          state_nxt = ST_IDLE_RD;
          bus_nxt   = '{addr: IDLE_ADDR, data: 8'h00, rw: 1'b1};
        end
      end
      ST_OPR2:
      begin
        pc_nxt    = pc_r + 16'h0001;
        ea_nxt    = {ext_hi_r, I_BUS_DIN};
        state_nxt = ST_WR_HI;
        bus_nxt   = '{addr: {ext_hi_r, I_BUS_DIN}, data: val16[15:8], rw: 1'b0};
      end
      ST_IDLE_RD:
      begin
        state_nxt = ST_WR_HI;
        bus_nxt   = '{addr: ea_r, data: val16[15:8], rw: 1'b0};
      end
      ST_WR_HI, ST_WR_LO:
      begin
        if (state_r == ST_WR_HI && dec_r.wide)
        begin
          state_nxt = ST_WR_LO;
          bus_nxt   = '{addr: ea_r + 16'h0001, data: val16[7:0], rw: 1'b0};
        end
        else
        begin
          ccr_nxt[CCR_N_BIT] = val16[15];
          ccr_nxt[CCR_Z_BIT] = dec_r.wide ? (val16 == 16'h0000)
                                          : (val16[15:8] == 8'h00);
          ccr_nxt[CCR_V_BIT] = 1'b0;
          state_nxt = run_r ? ST_FETCH : ST_IDLE;
          bus_nxt   = '{addr: run_r ? pc_r : IDLE_ADDR, data: 8'h00, rw: 1'b1};
        end
      end
      ST_INH:
      begin
        if (ccr_r[CCR_S_BIT])
        begin
          state_nxt = run_r ? ST_FETCH : ST_IDLE;
          bus_nxt   = '{addr: run_r ? pc_r : IDLE_ADDR, data: 8'h00, rw: 1'b1};
        end
        else
        begin
          state_nxt = ST_STOPPED;
          halt_nxt  = 1'b1;
        end
      end
      ST_STOPPED:
      begin
        halt_nxt = 1'b1;
        if (nonmaskable_int_line_act)
        begin
          halt_nxt = 1'b0;
          if (!ccr_r[CCR_X_BIT])
          begin
            stack_nxt = 1'b1;
            run_clr   = 1'b1;
            state_nxt = ST_IDLE;
          end
          else
          begin
            state_nxt = ST_FETCH;
            bus_nxt   = '{addr: pc_r, data: 8'h00, rw: 1'b1};
          end
        end
        else if (irq_act && !ccr_r[CCR_I_BIT])
        begin
          halt_nxt  = 1'b0;
          irqw_nxt  = 1'b1;
          state_nxt = ST_FETCH;
          bus_nxt   = '{addr: pc_r, data: 8'h00, rw: 1'b1};
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      state_r      <= ST_IDLE;
      bus_r        <= '{addr: IDLE_ADDR, data: 8'h00, rw: 1'b1};
      dec_r        <= '{valid: 1'b0, mode: AM_NONE, src: SRC_A, wide: 1'b0};
      prefix_r     <= 8'h00;
      ea_r         <= 16'h0000;
      ext_hi_r     <= 8'h00;
      O_CLK_HALT   <= 1'b0;
      O_NONMASKABLE_INT_LINE_STACK <= 1'b0;
      O_IRQ_WAKE   <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      bus_r        <= bus_nxt;
      dec_r        <= dec_nxt;
      prefix_r     <= prefix_nxt;
      ea_r         <= ea_nxt;
      ext_hi_r     <= ext_hi_nxt;
      O_CLK_HALT   <= halt_nxt;
      O_NONMASKABLE_INT_LINE_STACK <= stack_nxt;
      O_IRQ_WAKE   <= irqw_nxt;
    end
  end
  assign O_BUS = bus_r;

  // One wait state so that read data comes from a flop
  assign apb_acc = I_PSEL && I_PENABLE && O_PREADY;
  assign apb_wr  = apb_acc && I_PWRITE;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_val  = 32'h0000_0000;
    if (I_PADDR == OFF_CTRL)
      rd_val = {31'h0000_0000, run_r};
    else if (I_PADDR == OFF_STATUS)
      rd_val = {29'h0000_0000, illeg_r, state_r == ST_STOPPED, state_r != ST_IDLE};
    else if (I_PADDR == OFF_PC)
      rd_val = {16'h0000, pc_r};
    else if (I_PADDR == OFF_ACC_A)
      rd_val = {24'h00_0000, acc_a_r};
    else if (I_PADDR == OFF_ACC_B)
      rd_val = {24'h00_0000, acc_b_r};
    else if (I_PADDR == OFF_IDX_X)
      rd_val = {16'h0000, idx_x_r};
    else if (I_PADDR == OFF_IDX_Y)
      rd_val = {16'h0000, idx_y_r};
    else if (I_PADDR == OFF_SP)
      rd_val = {16'h0000, sp_r};
    else if (I_PADDR == OFF_CCR)
      rd_val = {24'h00_0000, ccr_r};
    else
      addr_ok = 1'b0;
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      O_PREADY  <= I_PSEL && I_PENABLE && !O_PREADY;
      O_PRDATA  <= rd_val;
      O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && !addr_ok;
    end
  end

  // Control; the run bit set by software beats nothing, clears by hardware win
  always_ff @(posedge I_MCLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      run_r   <= 1'b0;
      illeg_r <= 1'b0;
    end
    else
    begin
      if (run_clr)
        run_r <= 1'b0;
      else if (apb_wr && I_PADDR == OFF_CTRL)
        run_r <= I_PWDATA[CTRL_RUN_BIT];
      if (illeg_set)
        illeg_r <= 1'b1;
      else if (apb_wr && I_PADDR == OFF_STATUS && I_PWDATA[STAT_ILLEG_BIT])
        illeg_r <= 1'b0;
    end
  end

  // Core registers are software-writable only while the sequencer is idle
  always_ff @(posedge I_MCLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      pc_r    <= PC_RST;
      ccr_r   <= CCR_RST;
      acc_a_r <= 8'h00;
      acc_b_r <= 8'h00;
      idx_x_r <= 16'h0000;
      idx_y_r <= 16'h0000;
      sp_r    <= SP_RST;
    end
    else if (state_r == ST_IDLE && apb_wr)
    begin
      if (I_PADDR == OFF_PC)
        pc_r <= I_PWDATA[15:0];
      else if (I_PADDR == OFF_ACC_A)
        acc_a_r <= I_PWDATA[7:0];
      else if (I_PADDR == OFF_ACC_B)
        acc_b_r <= I_PWDATA[7:0];
      else if (I_PADDR == OFF_IDX_X)
        idx_x_r <= I_PWDATA[15:0];
      else if (I_PADDR == OFF_IDX_Y)
        idx_y_r <= I_PWDATA[15:0];
      else if (I_PADDR == OFF_SP)
        sp_r <= I_PWDATA[15:0];
      else if (I_PADDR == OFF_CCR)
        ccr_r <= I_PWDATA[7:0];
    end
    else
    begin
      pc_r  <= pc_nxt;
      ccr_r <= ccr_nxt;
    end
  end

endmodule : sse_store_stop

// File: hdl/sse_pkg.sv
package sse_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PC     = 8'h08;
  localparam logic [7:0] OFF_ACC_A  = 8'h0C;
  localparam logic [7:0] OFF_ACC_B  = 8'h10;
  localparam logic [7:0] OFF_IDX_X  = 8'h14;
  localparam logic [7:0] OFF_IDX_Y  = 8'h18;
  localparam logic [7:0] OFF_SP     = 8'h1C;
  localparam logic [7:0] OFF_CCR    = 8'h20;

  // Field positions
  localparam int CTRL_RUN_BIT    = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_STOP_BIT   = 1;
  localparam int STAT_ILLEG_BIT  = 2;
  localparam int CCR_S_BIT       = 7;
  localparam int CCR_X_BIT       = 6;
  localparam int CCR_I_BIT       = 4;
  localparam int CCR_N_BIT       = 3;
  localparam int CCR_Z_BIT       = 2;
  localparam int CCR_V_BIT       = 1;

  // Values after reset
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [15:0] SP_RST  = 16'h0000;
  localparam logic [7:0]  CCR_RST = 8'hD0;
  localparam logic [15:0] IDLE_ADDR = 16'hFFFF;

  // Opcodes and prefixes
  localparam logic [7:0] OPC_STOP     = 8'hCF;
  localparam logic [7:0] OPC_PRE_Y    = 8'h18;
  localparam logic [7:0] OPC_PRE_XY   = 8'hCD;
  localparam logic [7:0] OPC_STX_IND  = 8'hEF;

  typedef enum logic [1:0] {
    AM_NONE = 2'b00,
    AM_DIR  = 2'b01,
    AM_IND  = 2'b10,
    AM_EXT  = 2'b11
  } sse_mode_t;

  typedef enum logic [2:0] {
    SRC_A  = 3'b000,
    SRC_B  = 3'b001,
    SRC_D  = 3'b010,
    SRC_SP = 3'b011,
    SRC_X  = 3'b100
  } sse_src_t;

  typedef struct packed {
    logic      valid;
    sse_mode_t mode;
    sse_src_t  src;
    logic      wide;
  } sse_dec_t;

  // One processor bus cycle
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rw;
  } sse_bus_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_FETCH   = 4'b0001,
    ST_PREFIX  = 4'b0010,
    ST_OPR1    = 4'b0011,
    ST_OPR2    = 4'b0100,
    ST_IDLE_RD = 4'b0101,
    ST_WR_HI   = 4'b0110,
    ST_WR_LO   = 4'b0111,
    ST_INH     = 4'b1000,
    ST_STOPPED = 4'b1001
  } sse_state_t;

endpackage : sse_pkg

// File: verif/sse_mem.sv
`timescale 1ns/1ps
module sse_mem
  import sse_pkg::*;
(
  // Processor bus
  input  wire sse_pkg::sse_bus_t i_bus,
  input  wire logic              i_clk,
  // Read data
  output logic [7:0]             o_din
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;

  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    last_r = 8'h00;
  end

  // Undriven in write cycles: show the inverse of the byte seen one cycle earlier
  assign o_din = i_bus.rw ? mem[i_bus.addr] : ~last_r;

  always @(posedge i_clk)
  begin
    if (i_bus.rw === 1'b0)
      mem[i_bus.addr] <= i_bus.data;
    last_r <= o_din;
  end
endmodule : sse_mem

// File: verif/sse_store_stop_chk.sv
`timescale 1ns/1ps
module sse_store_stop_chk
  import sse_pkg::*;
(
  // Inputs of the block
  input wire logic              I_MCLK,
  input wire logic              I_RESET_N,
  input wire logic              I_PSEL,
  input wire logic              I_PENABLE,
  input wire logic              I_NONMASKABLE_INT_LINE_N,
  input wire logic              I_IRQ_N,
  // Outputs of the block
  input wire logic              O_PREADY,
  input wire logic              O_PSLVERR,
  input wire sse_pkg::sse_bus_t O_BUS,
  input wire logic              O_CLK_HALT,
  input wire logic              O_NONMASKABLE_INT_LINE_STACK,
  input wire logic              O_IRQ_WAKE
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RESET_N);

  // Wake lines pass a two-flop synchroniser, so look back four edges
  logic [3:0] int_hist_r;
  always_ff @(posedge I_MCLK or negedge I_RESET_N)
    if (!I_RESET_N)
      int_hist_r <= 4'h0;
    else
      int_hist_r <= {int_hist_r[2:0], !I_NONMASKABLE_INT_LINE_N || !I_IRQ_N};

  sequence s_wr2;
    !O_BUS.rw ##1 !O_BUS.rw;
  endsequence
  sequence s_quiet3;
    (O_CLK_HALT && I_NONMASKABLE_INT_LINE_N && I_IRQ_N) [*3];
  endsequence

  chk_halt_bus_hold: assert property (O_CLK_HALT && $past(O_CLK_HALT) |-> $stable(O_BUS))
    else $error("bus moved while stopped");
  chk_halt_no_write: assert property (O_CLK_HALT |-> O_BUS.rw)
    else $error("write cycle while stopped");
  chk_pair_addr_inc: assert property (s_wr2 |-> O_BUS.addr == $past(O_BUS.addr) + 16'h0001)
    else $error("second write not at next address");
  chk_pair_max_two: assert property (s_wr2 |=> O_BUS.rw)
    else $error("more than two write cycles in a row");
  chk_wake_has_cause: assert property ($fell(O_CLK_HALT) |-> (|int_hist_r))
    else $error("left stop without a wake line");
  chk_stop_stays: assert property (s_quiet3 |=> O_CLK_HALT)
    else $error("left stop with wake lines idle");
  chk_stack_from_stop: assert property (O_NONMASKABLE_INT_LINE_STACK |-> $past(O_CLK_HALT) && !O_IRQ_WAKE)
    else $error("stacking hand-over outside a stop wake");
  chk_irq_wake_cause: assert property (O_IRQ_WAKE |-> $past(O_CLK_HALT) && (|int_hist_r))
    else $error("interrupt wake pulse without cause");
  chk_ready_after_enable: assert property (O_PREADY |-> $past(I_PSEL && I_PENABLE) ##1 !O_PREADY)
    else $error("ready not a single pulse after access phase");
  chk_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("slave error without ready");
endmodule : sse_store_stop_chk

bind sse_store_stop sse_store_stop_chk u_chk (
  .I_MCLK                   (I_MCLK),
  .I_RESET_N                (I_RESET_N),
  .I_PSEL                   (I_PSEL),
  .I_PENABLE                (I_PENABLE),
  .I_NONMASKABLE_INT_LINE_N (I_NONMASKABLE_INT_LINE_N),
  .I_IRQ_N                  (I_IRQ_N),
  .O_PREADY                 (O_PREADY),
  .O_PSLVERR                (O_PSLVERR),
  .O_BUS                    (O_BUS),
  .O_CLK_HALT               (O_CLK_HALT),
  .O_NONMASKABLE_INT_LINE_STACK             (O_NONMASKABLE_INT_LINE_STACK),
  .O_IRQ_WAKE               (O_IRQ_WAKE)
);

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sse_pkg::*;
  logic        clk, rst_n, psel, pen, pwr, nonmaskable_int_line_n, irq_n, err, prev_ff, stk_seen, wake_seen;
  logic        pready, pslverr, halt, stk, wake;
  logic [7:0]  paddr, din, ra, rb, off;
  logic [15:0] rx, ry, rsp, pc;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  q[$];
  sse_bus_t    bus;
  int          error_cnt, n_compared, cyc, nwr, nidle;

  sse_store_stop u_sse_store_stop (
    .I_MCLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_BUS_DIN(din), .O_BUS(bus), .I_NONMASKABLE_INT_LINE_N(nonmaskable_int_line_n),
    .I_IRQ_N(irq_n), .O_CLK_HALT(halt), .O_NONMASKABLE_INT_LINE_STACK(stk), .O_IRQ_WAKE(wake));
  sse_mem u_sse_mem (.i_bus(bus), .i_clk(clk), .o_din(din));

  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (bus.rw === 1'b0)
    begin
      nwr++;
      nidle += int'(prev_ff);
    end
    prev_ff = bus.addr === IDLE_ADDR && bus.rw === 1'b1;
    if (stk === 1'b1) stk_seen = 1;
    if (wake === 1'b1) wake_seen = 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      stop_test;
    end
  end

  task stop_test;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pwr <= w; paddr <= a; pwdata <= d; pen <= 0;
    @(posedge clk);
    pen <= 1;
    // No local limit: only the cycle ceiling may end a wait for ready
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
  endtask : apb

  task automatic start(input logic [7:0] c);
    apb(1, OFF_ACC_A, {24'h0, ra}); apb(1, OFF_ACC_B, {24'h0, rb});
    apb(1, OFF_IDX_X, {16'h0, rx}); apb(1, OFF_IDX_Y, {16'h0, ry});
    apb(1, OFF_SP, {16'h0, rsp}); apb(1, OFF_CCR, {24'h0, c});
    pc = 16'h4000 + 16'($urandom % 4096);
    foreach (q[i]) u_sse_mem.mem[pc + i] = q[i];
    apb(1, OFF_PC, {16'h0, pc}); apb(1, OFF_STATUS, 32'h4);
    nwr = 0; nidle = 0; stk_seen = 0; wake_seen = 0;
    apb(1, OFF_CTRL, 32'h1);
  endtask : start

  task automatic wait_done;
    repeat (30)
    begin
      apb(0, OFF_STATUS, 0);
      if (rd[STAT_BUSY_BIT] === 1'b0) break;
    end
    // A sequencer that never goes idle counts as a mismatch
    chk(rd[STAT_BUSY_BIT], 1'b0);
  endtask : wait_done

  task automatic store_test(input int s, input int m);
    logic [7:0]  base[5] = '{8'h97, 8'hD7, 8'hDD, 8'h9F, 8'hDF};
    logic [15:0] v, ea;
    logic [7:0]  c;
    logic        w;
    ra = 8'($urandom); rb = 8'($urandom); rsp = 16'($urandom); off = 8'($urandom);
    rx = 16'h8000 | 16'($urandom % 4096); ry = 16'h9000 | 16'($urandom % 4096);
    if ($urandom % 4 == 0) {ra, rb, rsp, rx} = '0;
    c = 8'h80 | 8'($urandom);
    ea = m == 0 ? {8'h00, off} : m == 1 ? {8'hA0, off} : (m == 2 ? rx : ry) + {8'h00, off};
    v = s == 0 ? {8'h00, ra} : s == 1 ? {8'h00, rb} : s == 2 ? {ra, rb} : s == 3 ? rsp : rx;
    w = s >= 2;
    q = {};
    if (m == 3) q.push_back(s == 4 ? OPC_PRE_XY : OPC_PRE_Y);
    q.push_back(base[s] + (m == 1 ? 8'h20 : m >= 2 ? 8'h10 : 8'h00));
    if (m == 1) q.push_back(8'hA0);
    q.push_back(off);
    q.push_back(8'h00);
    u_sse_mem.mem[ea] = ~v[7:0];
    u_sse_mem.mem[ea + 16'h1] = 8'h5A;
    start(c);
    wait_done;
    chk(u_sse_mem.mem[ea], w ? v[15:8] : v[7:0]);
    chk(u_sse_mem.mem[ea + 16'h1], w ? v[7:0] : 8'h5A);
    chk(nwr, w ? 2 : 1);
    chk(nidle, m >= 2);
    apb(0, OFF_CCR, 0);
    chk(rd, (c & 8'hF1) | {w ? v[15] : v[7], w ? v == 0 : v[7:0] == 0, 2'b00});
    apb(0, OFF_ACC_A, 0);
    chk(rd, ra);
  endtask : store_test

  task automatic go_stop(input logic [7:0] c);
    int n;
    ra = 8'($urandom); off = 8'($urandom);
    // Stop opens the program, so no opcode from the risky columns precedes it
    q = '{OPC_STOP, 8'h97, off, 8'h00};
    u_sse_mem.mem[{8'h00, off}] = ~ra;
    start(c);
    n = 0;
    while (!c[CCR_S_BIT] && halt !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
  endtask : go_stop

  task automatic wake_by(input logic w);
    @(posedge clk);
    if (w) irq_n <= 0;
    else nonmaskable_int_line_n <= 0;
    repeat (6) @(posedge clk);
    irq_n <= 1;
    nonmaskable_int_line_n <= 1;
    repeat (6) @(posedge clk);
  endtask : wake_by

  task automatic halt_case(input logic [7:0] c, input logic use_irq);
    go_stop(c);
    if (!c[CCR_S_BIT])
    begin
      chk(halt, 1);
      chk(u_sse_mem.mem[{8'h00, off}], 8'(~ra));
      if (c[CCR_I_BIT]) wake_by(1);
      chk(halt, 1);
      wake_by(use_irq);
      chk(halt, 0);
      chk(stk_seen, !use_irq && !c[CCR_X_BIT]);
      chk(wake_seen, use_irq);
    end
    wait_done;
    chk(halt, 0);
    chk(u_sse_mem.mem[{8'h00, off}], (use_irq || c[CCR_X_BIT]) ? ra : 8'(~ra));
  endtask : halt_case

  initial
  begin
    rst_n = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0; nonmaskable_int_line_n = 1; irq_n = 1;
    void'($urandom(60617));
    repeat (20) @(posedge clk);
    rst_n <= 1;
    apb(0, OFF_CCR, 0);
    chk(rd, CCR_RST);
    apb(0, 8'h40, 0);
    chk({rd[30:0], err}, 1);
    for (int s = 0; s < 5; s++)
      for (int m = 0; m < 4; m++) store_test(s, m);
    repeat (30) store_test($urandom % 5, $urandom % 4);
    halt_case(8'hD0, 0);
    halt_case(8'h50, 0);
    halt_case(8'h10, 0);
    halt_case(8'h40, 1);
    go_stop(8'h50);
    @(posedge clk);
    rst_n <= 0;
    repeat (3) @(posedge clk);
    chk(halt, 0);
    chk(bus, {IDLE_ADDR, 8'h00, 1'b1});
    rst_n <= 1;
    store_test(2, 3);
    stop_test;
  end
endmodule : testbench
